// ===== src/gpio_pkg.sv
package gpio_pkg;

   // ==========================================================
   // Register map
   localparam int APB_ADDR_WIDTH = 8;
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // ==========================================================
   // Control register fields
   localparam int CTRL_WIDTH = 5;
   localparam int CTRL_IN_REG_BIT = 0;
   localparam int CTRL_OUT_REG_BIT = 1;
   localparam int CTRL_OE_REG_BIT = 2;
   localparam int CTRL_DUAL_BIT = 3;
   localparam int CTRL_RESYNC_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h07;

   // ==========================================================
   // Status register fields
   localparam int STAT_IN_LSB = 0;
   localparam int STAT_PAD_BIT = 2;
   localparam int STAT_OE_BIT = 3;
   localparam int STAT_OUT_BIT = 4;
   localparam int STAT_DUAL_BIT = 5;
   localparam int STAT_CAPABLE_BIT = 6;

   // ==========================================================
   // Pin sampling
   localparam int SYNC_STAGES = 3;
   localparam int PIN_COUNT = 3;
   localparam int PIN_PAD = 0;
   localparam int PIN_IN_CLK = 1;
   localparam int PIN_OUT_CLK = 2;

endpackage

// ===== src/sampled_pins_if.sv
`timescale 1ns/10ps
interface sampled_pins_if #(
   parameter int N = 3
);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;

   modport sampler (
      input raw,
      output level,
      output rise,
      output fall
   );
   modport user (
      output raw,
      input level,
      input rise,
      input fall
   );
endinterface

// ===== src/pin_filter.sv
`timescale 1ns/10ps
module pin_filter
   import gpio_pkg::*;
#(
   parameter int N = 3
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   sampled_pins_if.sampler pins
);

   // ==========================================================
   // Three-stage sampling, change accepted when stages two and three agree
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : gen_pin
         logic [SYNC_STAGES-1:0] stage_q;
         logic level_q;
         logic rise_q;
         logic fall_q;

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               stage_q <= '0;
            end else if (clk_en) begin
               stage_q <= {stage_q[SYNC_STAGES-2:0], pins.raw[g]};
            end
         end

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               level_q <= 1'b0;
               rise_q <= 1'b0;
               fall_q <= 1'b0;
            end else if (clk_en) begin
               rise_q <= 1'b0;
               fall_q <= 1'b0;
               if ((stage_q[1] == stage_q[2]) && (stage_q[2] != level_q)) begin
                  level_q <= stage_q[2];
                  rise_q <= stage_q[2];
                  fall_q <= ~stage_q[2];
               end
            end
         end

         assign pins.level[g] = level_q;
         assign pins.rise[g] = rise_q;
         assign pins.fall[g] = fall_q;
      end
   endgenerate

endmodule

// ===== src/dual_edge_gpio_interface.sv
`timescale 1ns/10ps
// What this block does
// (RQ1) Dual-edge off: input only on bit 0
// (RQ2) Dual-edge input: rising sample on bit 0
// (RQ3) Dual-edge input: falling sample on bit 1
// (RQ4) Dual-edge off: pad driven from bit 0
// (RQ5) Dual-edge output: bit 0 rising, bit 1 falling
// (RQ6) Output and enable use output clock; enable bypassable
// (RQ7) Input registers use separate input clock
// (RQ8) No input register: pad goes to bypass output
// (RQ9) Dual-edge moves two bits per clock
// (RQ10) Normal sub-mode: each bit on own edge
// (RQ11) Resync sub-mode: core sees rising-edge changes only
// (RQ12) Resync: falling sample delayed half a cycle
// (RQ13) Dual-edge only on capable cells
// (RQ14) Core must not enable unsupported dual-edge
// (RQ15) Pad driven only while enable high
module dual_edge_gpio_interface
   import gpio_pkg::*;
#(
   parameter bit DUAL_EDGE_CAPABLE = 1'b1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [APB_ADDR_WIDTH-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic input_side_clock,
   input wire logic output_side_clock,
   input wire logic [1:0] out_data,
   input wire logic oe,
   output logic [1:0] in_data,
   output logic bypass_input,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe
);

   // ==========================================================
   // Elaboration checks
   generate
      if (APB_ADDR_WIDTH < 3) begin : gen_bad_addr
         $error("Address width too small for register map");
      end
      if (SYNC_STAGES < 3) begin : gen_bad_sync
         $error("Pin sampling needs three stages");
      end
      if ((PIN_PAD == PIN_IN_CLK) || (PIN_PAD == PIN_OUT_CLK) || (PIN_IN_CLK == PIN_OUT_CLK)) begin : gen_bad_share
         $error("Sampled pins share a slot");
      end
      if ((PIN_PAD >= PIN_COUNT) || (PIN_IN_CLK >= PIN_COUNT) || (PIN_OUT_CLK >= PIN_COUNT)) begin : gen_bad_index
         $error("Sampled pin slot beyond sampler width");
      end
      if ((CTRL_IN_REG_BIT >= CTRL_WIDTH) || (CTRL_OUT_REG_BIT >= CTRL_WIDTH)) begin : gen_bad_ctrl_a
         $error("Register option bit beyond control width");
      end
      if ((CTRL_OE_REG_BIT >= CTRL_WIDTH) || (CTRL_DUAL_BIT >= CTRL_WIDTH) || (CTRL_RESYNC_BIT >= CTRL_WIDTH)) begin : gen_bad_ctrl_b
         $error("Mode bit beyond control width");
      end
      if ((STAT_IN_LSB + 2 > STAT_PAD_BIT) || (STAT_CAPABLE_BIT > 31)) begin : gen_bad_status
         $error("Status fields overlap or leave the data word");
      end
      if (CTRL_OFFSET == STATUS_OFFSET) begin : gen_bad_map
         $error("Registers share an offset");
      end
   endgenerate

   // ==========================================================
   // Sampling of pad and the two core clocks
   sampled_pins_if #(.N(PIN_COUNT)) pins ();

   assign pins.raw[PIN_PAD] = pad_in;
   assign pins.raw[PIN_IN_CLK] = input_side_clock;
   assign pins.raw[PIN_OUT_CLK] = output_side_clock;

   pin_filter #(.N(PIN_COUNT)) u_pin_filter (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clk_en(clk_en),
      .pins(pins.sampler)
   );

   logic pad_level;
   logic in_rise;
   logic in_fall;
   logic out_rise;
   logic out_fall;

   assign pad_level = pins.level[PIN_PAD];
   assign in_rise = pins.rise[PIN_IN_CLK];
   assign in_fall = pins.fall[PIN_IN_CLK];
   assign out_rise = pins.rise[PIN_OUT_CLK];
   assign out_fall = pins.fall[PIN_OUT_CLK];

   // ==========================================================
   // Control register and derived modes
   logic [CTRL_WIDTH-1:0] ctrl_q;
   logic in_registered;
   logic out_registered;
   logic oe_registered;
   logic dual_on;
   logic resync_on;

   assign in_registered = ctrl_q[CTRL_IN_REG_BIT];
   assign out_registered = ctrl_q[CTRL_OUT_REG_BIT];
   assign oe_registered = ctrl_q[CTRL_OE_REG_BIT];
   assign dual_on = DUAL_EDGE_CAPABLE & ctrl_q[CTRL_DUAL_BIT]; // [RQ13] [RQ14]
   assign resync_on = ctrl_q[CTRL_RESYNC_BIT];

   // ==========================================================
   // APB slave
   logic ack_q;
   logic err_q;
   logic [31:0] rdata_q;
   logic setup_phase;
   logic access_done;
   logic addr_ctrl;
   logic addr_status;
   logic [31:0] status_word;

   assign setup_phase = psel & ~penable & clk_en;
   assign access_done = psel & penable & pready;
   assign addr_ctrl = (paddr == CTRL_OFFSET);
   assign addr_status = (paddr == STATUS_OFFSET);
   assign pready = ack_q & clk_en;
   assign pslverr = ack_q & err_q;
   assign prdata = rdata_q;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STAT_IN_LSB +: 2] = in_data;
      status_word[STAT_PAD_BIT] = pad_level;
      status_word[STAT_OE_BIT] = pad_oe;
      status_word[STAT_OUT_BIT] = pad_out;
      status_word[STAT_DUAL_BIT] = dual_on;
      status_word[STAT_CAPABLE_BIT] = DUAL_EDGE_CAPABLE;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (setup_phase) begin
            if (addr_ctrl && !pwrite) begin
               rdata_q <= {{(32 - CTRL_WIDTH){1'b0}}, ctrl_q};
            end else if (addr_status && !pwrite) begin
               rdata_q <= status_word;
            end else begin
               rdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else if (clk_en) begin
         if (setup_phase) begin
            ack_q <= 1'b1;
            err_q <= ~(addr_ctrl | addr_status);
         end else if (access_done) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (clk_en) begin
         if (access_done && pwrite && addr_ctrl && pstrb[0]) begin
            ctrl_q <= pwdata[CTRL_WIDTH-1:0];
         end
      end
   end

   // ==========================================================
   // Input path, timed by the input-side clock when registered, else by the system clock
   logic [1:0] in_data_q;
   logic fall_hold_q;
   logic bypass_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         in_data_q <= 2'h0;
      end else if (clk_en) begin
         if (!in_registered) begin
            in_data_q <= {1'b0, pad_level}; // [RQ1]
         end else begin
            if (dual_on && resync_on) begin
               if (in_rise) begin
                  in_data_q <= {fall_hold_q, pad_level}; // [RQ11] [RQ12] [RQ9]
               end
            end else if (dual_on) begin
               if (in_rise) begin
                  in_data_q[0] <= pad_level; // [RQ2] [RQ10] [RQ7]
               end
               if (in_fall) begin
                  in_data_q[1] <= pad_level; // [RQ3] [RQ10] [RQ9]
               end
            end else if (in_rise) begin
               in_data_q <= {1'b0, pad_level}; // [RQ1] [RQ7]
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fall_hold_q <= 1'b0;
      end else if (clk_en) begin
         if (in_fall) begin
            fall_hold_q <= pad_level; // [RQ12]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bypass_q <= 1'b0;
      end else if (clk_en) begin
         if (!in_registered) begin
            bypass_q <= pad_level; // [RQ8]
         end else begin
            bypass_q <= 1'b0;
         end
      end
   end

   assign in_data = in_data_q;
   assign bypass_input = bypass_q;

   // ==========================================================
   // Output path, timed by the output-side clock when registered, else by the system clock
   logic pad_out_q;
   logic out_hold_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pad_out_q <= 1'b0;
      end else if (clk_en) begin
         if (!out_registered) begin
            pad_out_q <= out_data[0]; // [RQ4]
         end else if (dual_on && resync_on) begin
            if (out_rise) begin
               pad_out_q <= out_data[0]; // [RQ11] [RQ5]
            end else if (out_fall) begin
               pad_out_q <= out_hold_q; // [RQ11] [RQ5] [RQ9]
            end
         end else if (dual_on) begin
            if (out_rise) begin
               pad_out_q <= out_data[0]; // [RQ5] [RQ10] [RQ6]
            end else if (out_fall) begin
               pad_out_q <= out_data[1]; // [RQ5] [RQ10] [RQ9]
            end
         end else if (out_rise) begin
            pad_out_q <= out_data[0]; // [RQ4] [RQ6]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         out_hold_q <= 1'b0;
      end else if (clk_en) begin
         if (out_rise) begin
            out_hold_q <= out_data[1]; // [RQ11]
         end
      end
   end

   // ==========================================================
   // Output enable, registered or passed through
   logic oe_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         oe_q <= 1'b0;
      end else if (clk_en) begin
         if (!oe_registered) begin
            oe_q <= oe; // [RQ6]
         end else if (out_rise) begin
            oe_q <= oe; // [RQ6]
         end
      end
   end

   // ==========================================================
   // Pad drive
   assign pad_out = pad_out_q;
   assign pad_oe = oe_q; // [RQ15]

endmodule

// ===== testbench/gpio_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module gpio_checker
   import gpio_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [APB_ADDR_WIDTH-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic input_side_clock,
   input wire logic [1:0] out_data,
   input wire logic oe,
   input wire logic [1:0] in_data,
   input wire logic bypass_input,
   input wire logic pad_in,
   input wire logic pad_out,
   input wire logic pad_oe
);
   logic [4:0] ctrl_q;
   logic [3:0] age_q;
   logic settled;
   assign settled = age_q == 4'hF;
   // Shadow of the mode bits, and time since the last change
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RESET;
         age_q <= 4'h0;
      end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == CTRL_OFFSET) begin
         ctrl_q <= pwdata[4:0];
         age_q <= 4'h0;
      end else if (!settled) begin
         age_q <= age_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_in1_quiet;
      settled && !ctrl_q[CTRL_DUAL_BIT] |-> !$rose(in_data[1]);
   endproperty
   a_in1_quiet: assert property (p_in1_quiet) else $error("bit 1 rose in single mode");
   property p_in0_rise;
      settled && ctrl_q[CTRL_IN_REG_BIT] && $changed(in_data[0]) |-> $past(input_side_clock, 4);
   endproperty
   a_in0_rise: assert property (p_in0_rise) else $error("bit 0 moved off rising edge");
   property p_in1_fall;
      settled && ctrl_q[CTRL_IN_REG_BIT] && ctrl_q[CTRL_DUAL_BIT] && !ctrl_q[CTRL_RESYNC_BIT]
         && $changed(in_data[1]) |-> !$past(input_side_clock, 4);
   endproperty
   a_in1_fall: assert property (p_in1_fall) else $error("bit 1 moved off falling edge");
   property p_in1_resync;
      settled && ctrl_q[CTRL_IN_REG_BIT] && ctrl_q[CTRL_DUAL_BIT] && ctrl_q[CTRL_RESYNC_BIT]
         && $changed(in_data[1]) |-> $past(input_side_clock, 4);
   endproperty
   a_in1_resync: assert property (p_in1_resync) else $error("resync bit 1 off rising edge");
   property p_bypass_off;
      settled && ctrl_q[CTRL_IN_REG_BIT] |-> !bypass_input;
   endproperty
   a_bypass_off: assert property (p_bypass_off) else $error("bypass active while registered");
   property p_bypass_on;
      (settled && !ctrl_q[CTRL_IN_REG_BIT] && $stable(pad_in)) [*6] |-> bypass_input == pad_in;
   endproperty
   a_bypass_on: assert property (p_bypass_on) else $error("bypass does not follow pad");
   property p_oe_direct;
      settled && !ctrl_q[CTRL_OE_REG_BIT] && $stable(oe) |-> pad_oe == oe;
   endproperty
   a_oe_direct: assert property (p_oe_direct) else $error("unregistered enable wrong");
   property p_out_single;
      settled && !ctrl_q[CTRL_DUAL_BIT] && !ctrl_q[CTRL_OUT_REG_BIT] && $stable(out_data)
         |-> pad_out == out_data[0];
   endproperty
   a_out_single: assert property (p_out_single) else $error("pad not from bit 0");
endmodule
bind dual_edge_gpio_interface gpio_checker chk (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .input_side_clock(input_side_clock), .out_data(out_data), .oe(oe), .in_data(in_data),
   .bypass_input(bypass_input), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// ===== testbench/core_fabric_model.sv
`timescale 1ns/10ps
// ==========================================================
// Core fabric model: core clocks, output data and enable
module core_fabric_model (
   input wire logic clk_sys,
   input wire logic run,
   input wire logic [1:0] data_set,
   input wire logic oe_set,
   output logic input_side_clock,
   output logic output_side_clock,
   output logic [1:0] out_data,
   output logic oe
);
   logic [3:0] cnt_q = 4'h0;
   // Clocks stand still unless run, at a sixteenth of the system clock
   always @(posedge clk_sys) begin
      if (run) begin
         cnt_q <= cnt_q + 4'h1;
      end
      input_side_clock <= cnt_q[3];
      output_side_clock <= cnt_q[3];
   end
   // Pair launched after the rise: bit 0 for rising, bit 1 for falling
   always @(posedge clk_sys) begin
      if (cnt_q == 4'h9 || !run) begin
         out_data <= data_set;
         oe <= oe_set;
      end
   end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Testbench
module testbench
   import gpio_pkg::*;
;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic clk_en = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic run = 1'h0;
   logic oe_set = 1'h0;
   logic [1:0] data_set = 2'h0;
   logic [1:0] pad_sel = 2'h0;
   logic [31:0] prdata;
   logic pready, pslverr, isc, osc, oe, bypass_input, pad_out, pad_oe, pad_in;
   logic [1:0] out_data, in_data;
   int mismatches = 0;
   int comparisons = 0;
   always #50 clk_sys = ~clk_sys;
   // Pad wire: design drives while enabled, else the bench source
   assign pad_in = pad_oe ? pad_out : (pad_sel[1] ? isc ^ pad_sel[0] : pad_sel[0]);
   dual_edge_gpio_interface dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .input_side_clock(isc), .output_side_clock(osc),
      .out_data(out_data), .oe(oe), .in_data(in_data), .bypass_input(bypass_input), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe));
   core_fabric_model core (.clk_sys(clk_sys), .run(run), .data_set(data_set), .oe_set(oe_set),
      .input_side_clock(isc), .output_side_clock(osc), .out_data(out_data), .oe(oe));
   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, 4'h0, r, e);
      check(r, x);
      check({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, s, r, e);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'h1;
      rd(CTRL_OFFSET, 32'h7, 1'h0);
      rd(8'h08, 32'h0, 1'h1);
      wr(CTRL_OFFSET, 32'hFFFFFFE3, 4'h1);
      wr(STATUS_OFFSET, 32'h0, 4'hF);
      wr(CTRL_OFFSET, 32'h1F, 4'h0);
      rd(CTRL_OFFSET, 32'h3, 1'h0);
      $display("test registers done");
      wr(CTRL_OFFSET, 32'h0, 4'h1);
      for (int i = 0; i < 4; i++) begin
         oe_set <= i[1];
         data_set <= {~i[0], i[0]};
         pad_sel <= {1'h0, ~i[0]};
         repeat (20) @(posedge clk_sys);
         check(pad_oe, i[1]);
         check(pad_out, i[0]);
         check(bypass_input, i[1] ? i[0] : !i[0]);
      end
      $display("test bypass done");
      wr(CTRL_OFFSET, 32'h7, 1'h1);
      oe_set <= 1'h0;
      run <= 1'h1;
      for (int i = 0; i < 2; i++) begin
         pad_sel <= {1'h1, i[0]};
         repeat (40) @(posedge clk_sys);
         check(in_data, {1'h0, ~i[0]});
      end
      $display("test single done");
      for (int k = 0; k < 4; k++) begin
         wr(CTRL_OFFSET, k[1] ? 32'h1F : 32'hF, 4'h1);
         oe_set <= 1'h0;
         pad_sel <= {1'h1, k[0]};
         data_set <= {k[0], ~k[0]};
         repeat (40) @(posedge clk_sys);
         check(in_data, k[0] ? 2'h2 : 2'h1);
         oe_set <= 1'h1;
         repeat (40) @(posedge clk_sys);
         @(posedge osc);
         repeat (7) @(posedge clk_sys);
         check(pad_out, !k[0]);
         @(negedge osc);
         repeat (7) @(posedge clk_sys);
         check(pad_out, k[0]);
         check(pad_oe, 1'h1);
      end
      $display("test dual done");
      run <= 1'h0;
      test_done();
   end
   // Watchdog: the tests need well under a tenth of this span
   initial begin
      #2000000;
      mismatches++;
      test_done();
   end
endmodule
